// [csp_regs.vh]
// Register offsets, field positions, reset values and timing constants for the clock synthesizer control.
// Functional notes
// [R01] Software writes divider control, then M divisor, then N divisor.
// [R02] N-divisor write copies all three staged registers to the selected VCO at once.
// [R03] Program pointer 0 targets video VCO, 1 memory VCO; transfer is synchronous.
// [R04] Divider bit 0: 0 divides reference by four, 1 passes it undivided.
// [R05] Post-divider bits 3-1 divide output by two to the field value.
// [R06] Loop-divide bit: 0 feedback divides by 4*M, 1 by 16*M.
// [R07] Divide-by-five bit divides reference by five for dot clock only.
// [R08] M-divisor register holds a full eight-bit M value.
// [R09] N-divisor register holds a full eight-bit N and triggers commit.
// [R10] VCO power-down bits disable their VCO only with internal source selected.
// [R11] Oscillator power-down acts only with oscillator enable and external sequencing reference.
// [R12] Video clock select picks video VCO/reference, or memory clock divided by two.
// [R13] Sequencing clock is reference divided by 384, or external 32 KHz pin.
// [R14] Software avoids asymmetric DRAM while external 32 KHz reference is selected.
// [R15] ISO bit selects default clock 0/1 frequencies: 25.175/28.322 or 32/36 MHz.
// [R16] After reset VCOs and oscillator run, video select 0, divided reference clock.
// [R17] VCOs keep committed parameters until N write; staged values read back.
`ifndef CSP_REGS_VH
`define CSP_REGS_VH
`define CSP_IDX_DIV_CTRL 8'h30
`define CSP_IDX_M_DIV 8'h31
`define CSP_IDX_N_DIV 8'h32
`define CSP_IDX_CLK_CTRL 8'h33
`define CSP_DIV_REF_SEL 0
`define CSP_DIV_POST_LO 1
`define CSP_DIV_POST_HI 3
`define CSP_DIV_LOOP 4
`define CSP_DIV_REF5 5
`define CSP_CTL_VPD 0
`define CSP_CTL_MPD 1
`define CSP_CTL_OPD 2
`define CSP_CTL_VSEL 4
`define CSP_CTL_PTR 5
`define CSP_CTL_PSEQ 6
`define CSP_CTL_ISO 7
`define CSP_RST_DIV_CTRL 8'h00
`define CSP_RST_M_DIV 8'h00
`define CSP_RST_N_DIV 8'h00
`define CSP_RST_CLK_CTRL 8'h00
`define CSP_PSEQ_DIV 9'h180
`define CSP_PSEQ_HALF 9'h0C0
`define CSP_FREQ0_STD_KHZ 16'h6257
`define CSP_FREQ1_STD_KHZ 16'h6EA2
`define CSP_FREQ0_ISO_KHZ 16'h7D00
`define CSP_FREQ1_ISO_KHZ 16'h8CA0
`endif

// [csp_vco_file.v]
// Two-entry VCO register file holding committed loop parameters.
`timescale 1ns/1ps
`default_nettype none
module csp_vco_file (
    input wire sys_clk, // Reference clock.
    input wire rst_n, // Synchronous reset, active low.
    input wire wr_en, // Commit strobe.
    input wire wr_sel, // Target entry: 0 video, 1 memory.
    input wire [23:0] wr_data, // Divider control, M and N.
    output reg [23:0] vid_q, // Video VCO parameters.
    output reg [23:0] mem_q // Memory VCO parameters.
);
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            vid_q <= 24'h000000;
            mem_q <= 24'h000000;
        end else if (wr_en) begin
            if (wr_sel) begin
                mem_q <= wr_data;
            end else begin
                vid_q <= wr_data;
            end
        end
    end
endmodule
`default_nettype wire

// [csp_ctrl.v]
// Clock synthesizer programming and control block.
`timescale 1ns/1ps
`default_nettype none
`include "csp_regs.vh"
module csp_ctrl (
    input wire sys_clk, // Reference clock.
    input wire rst_n, // Synchronous reset, active low.
    input wire [7:0] reg_index, // Extension register index.
    input wire reg_wr, // Write strobe, one cycle.
    input wire reg_rd, // Read strobe, one cycle.
    input wire [7:0] reg_wdata, // Write data.
    output reg [7:0] reg_rdata, // Read data, valid cycle after reg_rd.
    output reg reg_rvalid, // Read data valid pulse.
    input wire int_clk_src, // Clock source config: internal source selected.
    input wire osc_ctrl_en, // Clock source config: oscillator control enable.
    input wire ext_32k_in, // 32 KHz input on the spare address pin.
    output reg vid_ref_div4_r, // Video VCO: reference divided by 4.
    output reg [7:0] vid_post_div_r, // Video VCO post divide factor.
    output reg vid_loop16_r, // Video VCO: loop divides by 16*M.
    output reg vid_ref_div5_r, // Video VCO: reference divided by 5.
    output reg [7:0] vid_m_r, // Video VCO M divisor.
    output reg [7:0] vid_n_r, // Video VCO N divisor.
    output reg mem_ref_div4_r, // Memory VCO: reference divided by 4.
    output reg [7:0] mem_post_div_r, // Memory VCO post divide factor.
    output reg mem_loop16_r, // Memory VCO: loop divides by 16*M.
    output reg [7:0] mem_m_r, // Memory VCO M divisor.
    output reg [7:0] mem_n_r, // Memory VCO N divisor.
    output reg vid_vco_pd_r, // Video VCO powered down.
    output reg mem_vco_pd_r, // Memory VCO powered down.
    output reg osc_pd_r, // Oscillator powered down.
    output reg [1:0] video_clk_src_r, // 0 video VCO, 1 reference, 2 memory clock/2.
    output reg pseq_clk_r, // Panel sequencing and refresh clock.
    output reg [15:0] clk0_dflt_khz_r, // Default clock 0 frequency in kHz.
    output reg [15:0] clk1_dflt_khz_r // Default clock 1 frequency in kHz.
);
    localparam PS_IDLE = 1'b0;
    localparam PS_STAGED = 1'b1;

    reg [7:0] div_ctrl_r;
    reg [7:0] m_div_r;
    reg [7:0] n_div_r;
    reg [7:0] clk_ctrl_r;
    reg commit_r;
    reg commit_sel_r;
    reg prog_state_r;
    reg prog_state_nxt;
    reg [8:0] pseq_cnt_r;
    reg ext_32k_q_r;
    wire [23:0] vid_par;
    wire [23:0] mem_par;
    wire wr_div = reg_wr && (reg_index == `CSP_IDX_DIV_CTRL);
    wire wr_m = reg_wr && (reg_index == `CSP_IDX_M_DIV);
    wire wr_n = reg_wr && (reg_index == `CSP_IDX_N_DIV);
    wire wr_ctl = reg_wr && (reg_index == `CSP_IDX_CLK_CTRL);

    // Staged registers keep what software wrote; VCOs only see committed copies.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            div_ctrl_r <= `CSP_RST_DIV_CTRL;
            m_div_r <= `CSP_RST_M_DIV;
            n_div_r <= `CSP_RST_N_DIV;
            clk_ctrl_r <= `CSP_RST_CLK_CTRL; // [R16]
            commit_r <= 1'b0;
            commit_sel_r <= 1'b0;
        end else begin
            if (wr_div) begin
                div_ctrl_r <= reg_wdata; // [R17]
            end
            if (wr_m) begin
                m_div_r <= reg_wdata; // [R08]
            end
            if (wr_n) begin
                n_div_r <= reg_wdata; // [R09]
            end
            if (wr_ctl) begin
                clk_ctrl_r <= reg_wdata;
            end
            // Commit fires the cycle after the N write so the new N is in the staged copy.
            commit_r <= wr_n; // [R02]
            commit_sel_r <= clk_ctrl_r[`CSP_CTL_PTR]; // [R03]
        end
    end

    // Tracks whether a partial sequence is pending; informational only.
    always @* begin
        prog_state_nxt = prog_state_r;
        case (prog_state_r)
            PS_IDLE: begin
                if (wr_div || wr_m) begin
                    prog_state_nxt = PS_STAGED; // [R01]
                end
            end
            PS_STAGED: begin
                if (wr_n) begin
                    prog_state_nxt = PS_IDLE;
                end
            end
            default: begin
                prog_state_nxt = PS_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            prog_state_r <= PS_IDLE;
        end else begin
            prog_state_r <= prog_state_nxt;
        end
    end

    csp_vco_file u_vco_file (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .wr_en(commit_r), // [R02]
        .wr_sel(commit_sel_r), // [R03]
        .wr_data({div_ctrl_r, m_div_r, n_div_r}),
        .vid_q(vid_par),
        .mem_q(mem_par)
    );

    // Per-VCO decode of the committed divider word; entry 0 is video, entry 1 memory.
    // Both entries share one decode so the two synthesizers can never drift apart in meaning.
    wire [47:0] par_all = {mem_par, vid_par};
    wire [1:0] ref_div4_nxt;
    wire [15:0] post_div_nxt;
    wire [1:0] loop16_nxt;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_vco
            wire [7:0] ctl_word = par_all[24 * g + 16 +: 8];
            assign ref_div4_nxt[g] = ~ctl_word[`CSP_DIV_REF_SEL]; // [R04]
            assign post_div_nxt[8 * g +: 8] = 8'h01 << ctl_word[`CSP_DIV_POST_HI:`CSP_DIV_POST_LO]; // [R05]
            assign loop16_nxt[g] = ctl_word[`CSP_DIV_LOOP]; // [R06]
        end
    endgenerate

    // Register reads return staged values, one cycle after the strobe.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_index)
                    `CSP_IDX_DIV_CTRL: reg_rdata <= div_ctrl_r; // [R17]
                    `CSP_IDX_M_DIV: reg_rdata <= m_div_r;
                    `CSP_IDX_N_DIV: reg_rdata <= n_div_r;
                    `CSP_IDX_CLK_CTRL: reg_rdata <= clk_ctrl_r;
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Decode of committed parameters to VCO controls.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            vid_ref_div4_r <= 1'b1;
            vid_post_div_r <= 8'h01;
            vid_loop16_r <= 1'b0;
            vid_ref_div5_r <= 1'b0;
            vid_m_r <= 8'h00;
            vid_n_r <= 8'h00;
            mem_ref_div4_r <= 1'b1;
            mem_post_div_r <= 8'h01;
            mem_loop16_r <= 1'b0;
            mem_m_r <= 8'h00;
            mem_n_r <= 8'h00;
        end else begin
            vid_ref_div4_r <= ref_div4_nxt[0]; // [R04]
            vid_post_div_r <= post_div_nxt[7:0]; // [R05]
            vid_loop16_r <= loop16_nxt[0]; // [R06]
            vid_ref_div5_r <= vid_par[16 + `CSP_DIV_REF5]; // [R07]
            vid_m_r <= vid_par[15:8]; // [R08]
            vid_n_r <= vid_par[7:0]; // [R09]
            mem_ref_div4_r <= ref_div4_nxt[1]; // [R04]
            mem_post_div_r <= post_div_nxt[15:8]; // [R05]
            mem_loop16_r <= loop16_nxt[1]; // [R06]
            mem_m_r <= mem_par[15:8];
            mem_n_r <= mem_par[7:0];
        end
    end

    // Power-down gating and clock source selection.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            vid_vco_pd_r <= 1'b0; // [R16]
            mem_vco_pd_r <= 1'b0;
            osc_pd_r <= 1'b0;
            video_clk_src_r <= 2'h1;
            clk0_dflt_khz_r <= `CSP_FREQ0_STD_KHZ;
            clk1_dflt_khz_r <= `CSP_FREQ1_STD_KHZ;
        end else begin
            vid_vco_pd_r <= int_clk_src && clk_ctrl_r[`CSP_CTL_VPD]; // [R10]
            mem_vco_pd_r <= int_clk_src && clk_ctrl_r[`CSP_CTL_MPD]; // [R10]
            osc_pd_r <= osc_ctrl_en && clk_ctrl_r[`CSP_CTL_PSEQ] && clk_ctrl_r[`CSP_CTL_OPD]; // [R11]
            if (clk_ctrl_r[`CSP_CTL_VSEL]) begin
                video_clk_src_r <= 2'h2; // [R12]
            end else if (int_clk_src) begin
                video_clk_src_r <= 2'h0; // [R12]
            end else begin
                video_clk_src_r <= 2'h1;
            end
            if (clk_ctrl_r[`CSP_CTL_ISO]) begin
                clk0_dflt_khz_r <= `CSP_FREQ0_ISO_KHZ; // [R15]
                clk1_dflt_khz_r <= `CSP_FREQ1_ISO_KHZ;
            end else begin
                clk0_dflt_khz_r <= `CSP_FREQ0_STD_KHZ; // [R15]
                clk1_dflt_khz_r <= `CSP_FREQ1_STD_KHZ;
            end
        end
    end

    // Reference divided by 384 as a square wave, or the external pin; the pin is assumed synchronous.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            pseq_cnt_r <= 9'h000;
            ext_32k_q_r <= 1'b0;
            pseq_clk_r <= 1'b0;
        end else begin
            ext_32k_q_r <= ext_32k_in;
            if (pseq_cnt_r == (`CSP_PSEQ_DIV - 9'h001)) begin
                pseq_cnt_r <= 9'h000;
            end else begin
                pseq_cnt_r <= pseq_cnt_r + 9'h001;
            end
            if (clk_ctrl_r[`CSP_CTL_PSEQ]) begin
                pseq_clk_r <= ext_32k_q_r; // [R13]
            end else begin
                pseq_clk_r <= (pseq_cnt_r >= `CSP_PSEQ_HALF); // [R13]
            end
        end
    end
endmodule
`default_nettype wire

// [csp_ctrl_props.sv]
// Port checks for the clock synthesizer control block.
`timescale 1ns/1ps
`default_nettype none
module csp_ctrl_props (
    input wire sys_clk, // Clock.
    input wire rst_n, // Reset.
    input wire [7:0] reg_index, // Index.
    input wire reg_wr, // Write.
    input wire reg_rd, // Read.
    input wire [7:0] reg_wdata, // Data in.
    input wire [7:0] reg_rdata, // Data out.
    input wire reg_rvalid, // Valid.
    input wire vid_ref_div4_r, // Div 4.
    input wire [7:0] vid_post_div_r, // Post.
    input wire vid_loop16_r, // Loop.
    input wire vid_ref_div5_r, // Div 5.
    input wire [7:0] vid_m_r, // M.
    input wire [7:0] vid_n_r, // N.
    input wire [7:0] mem_post_div_r, // Post.
    input wire [7:0] mem_m_r, // M.
    input wire [7:0] mem_n_r, // N.
    input wire int_clk_src, // Internal source.
    input wire osc_ctrl_en, // Osc control.
    input wire vid_vco_pd_r, // Off.
    input wire mem_vco_pd_r, // Off.
    input wire osc_pd_r, // Off.
    input wire [1:0] video_clk_src_r, // Source.
    input wire [15:0] clk0_dflt_khz_r, // Clock 0.
    input wire [15:0] clk1_dflt_khz_r // Clock 1.
);
    reg [7:0] d_r, m_r, n_r, c_r;
    wire nw = reg_wr && reg_index == 8'h32;
    wire [7:0] rd_x = reg_index == 8'h30 ? d_r : reg_index == 8'h31 ? m_r :
        reg_index == 8'h32 ? n_r : reg_index == 8'h33 ? c_r : 8'h00;
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            d_r <= 8'h00;
            m_r <= 8'h00;
            n_r <= 8'h00;
            c_r <= 8'h00;
        end else if (reg_wr) begin
            if (reg_index == 8'h30) d_r <= reg_wdata;
            if (reg_index == 8'h31) m_r <= reg_wdata;
            if (nw) n_r <= reg_wdata;
            if (reg_index == 8'h33) c_r <= reg_wdata;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_vid; nw && !c_r[5]; endsequence
    sequence s_mem; nw && c_r[5]; endsequence
    a_read_answer: assert property (reg_rd |=> reg_rvalid && reg_rdata == $past(rd_x))
        else $error("Bad read.");
    a_valid_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("Stray valid.");
    a_commit_video: assert property (s_vid |-> ##3 vid_n_r == $past(reg_wdata, 3) &&
        vid_m_r == $past(m_r, 3) && vid_post_div_r == 8'h01 << $past(d_r[3:1], 3) &&
        vid_ref_div4_r == !$past(d_r[0], 3) && vid_loop16_r == $past(d_r[4], 3) &&
        vid_ref_div5_r == $past(d_r[5], 3)) else $error("Bad video commit.");
    a_commit_memory: assert property (s_mem |-> ##3 mem_n_r == $past(reg_wdata, 3) &&
        mem_m_r == $past(m_r, 3) && mem_post_div_r == 8'h01 << $past(d_r[3:1], 3))
        else $error("Bad memory commit.");
    a_hold_video: assert property (!$past(nw && !c_r[5], 3) |-> $stable(vid_n_r) && $stable(vid_m_r))
        else $error("Video moved.");
    a_video_clk_select: assert property ($past(c_r[4]) == c_r[4] && $past(c_r[4], 2) == c_r[4] |->
        (video_clk_src_r == 2'h2) == c_r[4]) else $error("Bad video source.");
    a_iso_default: assert property ($past(c_r[7]) == c_r[7] && $past(c_r[7], 2) == c_r[7] |->
        clk0_dflt_khz_r == (c_r[7] ? 16'h7D00 : 16'h6257) &&
        clk1_dflt_khz_r == (c_r[7] ? 16'h8CA0 : 16'h6EA2)) else $error("Bad default.");
    a_pd_video: assert property (vid_vco_pd_r == $past(c_r[0] && int_clk_src))
        else $error("Bad power down.");
    a_pd_memory: assert property (mem_vco_pd_r == $past(c_r[1] && int_clk_src))
        else $error("Bad memory power down.");
    a_osc_gate: assert property (osc_pd_r == $past(c_r[2] && c_r[6] && osc_ctrl_en))
        else $error("Bad osc.");
    a_reset_state: assert property (disable iff (1'b0) !rst_n |=> !vid_vco_pd_r && !osc_pd_r &&
        video_clk_src_r == 2'h1 && !reg_rvalid) else $error("Bad reset.");
endmodule
bind csp_ctrl csp_ctrl_props u_props (.*);
`default_nettype wire

// [tb_csp_ctrl.sv]
// Self-checking bench for the clock synthesizer control block.
`timescale 1ns/1ps
`default_nettype none
module tb_csp_ctrl;
    reg sys_clk = 1'b0;
    reg rst_n = 1'b0;
    reg [7:0] reg_index = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [7:0] reg_wdata = 8'h00;
    reg int_clk_src = 1'b0;
    reg osc_ctrl_en = 1'b0;
    reg ext_32k_in = 1'b0;
    wire [7:0] reg_rdata, vid_post_div_r, vid_m_r, vid_n_r, mem_post_div_r, mem_m_r, mem_n_r;
    wire reg_rvalid, vid_ref_div4_r, vid_loop16_r, vid_ref_div5_r, mem_ref_div4_r, mem_loop16_r;
    wire vid_vco_pd_r, mem_vco_pd_r, osc_pd_r, pseq_clk_r;
    wire [1:0] video_clk_src_r;
    wire [15:0] clk0_dflt_khz_r, clk1_dflt_khz_r;
    integer n_errors = 0;
    integer num_checks = 0;
    integer i, k;
    reg [31:0] r [0:7];
    csp_ctrl dut (.*);
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge pseq_clk_r) k = k + 1;
    task chk(input [39:0] got, input [39:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task w(input integer n);
        begin
            repeat (n) @(posedge sys_clk);
            #1;
        end
    endtask
    // Strobes drop one cycle before the next request so no signal is driven twice in a step.
    task wr(input [7:0] idx, input [7:0] d);
        begin
            reg_index = idx;
            reg_wdata = d;
            reg_wr = 1'b1;
            w(1);
            reg_wr = 1'b0;
            w(1);
        end
    endtask
    task rd(input [7:0] idx, input [7:0] exp);
        begin
            reg_index = idx;
            reg_rd = 1'b1;
            w(1);
            reg_rd = 1'b0;
            chk({reg_rvalid, reg_rdata}, {1'b1, exp});
            w(1);
        end
    endtask
    task give_verdict;
        begin
            $display("Checks %0d, errors %0d", num_checks, n_errors);
            if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        #100000;
        n_errors = n_errors + 1;
        give_verdict;
    end
    initial begin
        // Each row: pointer, divider word, M, N; rows cover every post-divide code.
        r[0] = 32'h00000102;
        r[1] = 32'h0103FF80;
        r[2] = 32'h00351020;
        r[3] = 32'h011755AA;
        r[4] = 32'h00283344;
        r[5] = 32'h010A7F01;
        r[6] = 32'h001C80FE;
        r[7] = 32'h01EFFFFF;
        w(10);
        rst_n = 1'b1;
        chk({vid_vco_pd_r, mem_vco_pd_r, osc_pd_r, video_clk_src_r, clk0_dflt_khz_r, clk1_dflt_khz_r},
            {5'h01, 16'h6257, 16'h6EA2});
        $display("Test reset done");
        for (i = 0; i < 8; i = i + 1) begin
            wr(8'h33, {2'b00, r[i][24], 5'h00});
            wr(8'h30, r[i][23:16]);
            wr(8'h31, r[i][15:8]);
            wr(8'h32, r[i][7:0]);
            w(1);
            if (r[i][24]) chk({mem_post_div_r, mem_m_r, mem_n_r, mem_ref_div4_r, mem_loop16_r},
                {8'h01 << r[i][19:17], r[i][15:0], ~r[i][16], r[i][20]});
            else chk({vid_post_div_r, vid_m_r, vid_n_r, vid_ref_div4_r, vid_loop16_r, vid_ref_div5_r},
                {8'h01 << r[i][19:17], r[i][15:0], ~r[i][16], r[i][20], r[i][21]});
            rd(8'h30, r[i][23:16]);
        end
        $display("Test commit rows done");
        wr(8'h31, 8'h5A);
        wr(8'h34, 8'h77);
        w(3);
        chk({vid_m_r, vid_n_r, mem_m_r}, 24'h80FEFF);
        rd(8'h31, 8'h5A);
        rd(8'h34, 8'h00);
        $display("Test staging done");
        int_clk_src = 1'b1;
        wr(8'h33, 8'h13);
        w(1);
        chk({vid_vco_pd_r, mem_vco_pd_r, video_clk_src_r}, 4'hE);
        int_clk_src = 1'b0;
        w(3);
        chk({vid_vco_pd_r, mem_vco_pd_r, video_clk_src_r}, 4'h2);
        wr(8'h33, 8'h00);
        w(1);
        chk(video_clk_src_r, 2'h1);
        int_clk_src = 1'b1;
        w(3);
        chk(video_clk_src_r, 2'h0);
        $display("Test clock select done");
        osc_ctrl_en = 1'b1;
        wr(8'h33, 8'h84);
        w(1);
        chk({osc_pd_r, clk0_dflt_khz_r, clk1_dflt_khz_r}, 33'h07D008CA0);
        wr(8'h33, 8'h44);
        ext_32k_in = 1'b1;
        w(3);
        chk({osc_pd_r, pseq_clk_r}, 2'h3);
        osc_ctrl_en = 1'b0;
        ext_32k_in = 1'b0;
        w(3);
        chk({osc_pd_r, pseq_clk_r}, 2'h0);
        wr(8'h33, 8'h00);
        w(3);
        k = 0;
        w(3840);
        chk(k, 10);
        $display("Test power and sequencing done");
        // Reset in mid-run must drop committed, staged and control state alike.
        wr(8'h33, 8'hD3);
        rst_n = 1'b0;
        w(3);
        rst_n = 1'b1;
        chk({vid_vco_pd_r, mem_vco_pd_r, video_clk_src_r, clk0_dflt_khz_r}, {4'h1, 16'h6257});
        chk({vid_m_r, mem_n_r, vid_post_div_r, vid_ref_div4_r}, {24'h000001, 1'b1});
        rd(8'h33, 8'h00);
        rd(8'h31, 8'h00);
        $display("Test mid-run reset done");
        give_verdict;
    end
endmodule
`default_nettype wire
